/* core/pct_pkg.sv */
// Purpose: Shared constants and carriers for the pulse controller timing core
// Assumes: One 250 MHz reference clock
// Notes: Cycle counts are in reference clock cycles
package pct_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ENV_ONE_ADDR = 8'h00;
	localparam logic [7:0] ENV_TWO_ADDR = 8'h04;
	localparam logic [7:0] COMMAND_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0C;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ENV1_SENSOR_FILTER_ENABLE_BIT = 0;
	localparam int ENV1_EPW_LSB = 4;
	localparam int ENV1_ETW_LSB = 8;
	localparam int ENV2_PULSE_FILTER_ENABLE_BIT = 0;
	localparam int ENV2_ENCODER_FILTER_ENABLE_BIT = 1;
	localparam int ENV2_GO_HALT_FILTER_ENABLE_BIT = 2;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_CLEAR_BIT = 2;
	localparam int CMD_LOAD_BIT = 3;
	localparam int CMD_PAT_LSB = 8;

	localparam logic [31:0] ENV1_RESET = 32'h0000_0000;
	localparam logic [31:0] ENV2_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam int RESET_DELAY_CYC = 8;
	localparam int PULSE_FILT_CYC = 3;
	localparam int ENC_FILT_CYC = 3;
	localparam int MANUAL_OFF_CYC = 131072;
	localparam int MANUAL_ON_CYC = 393216;
	localparam int SENSOR_FILT_CYC = 40;
	localparam int GOHALT_OFF_CYC = 5;
	localparam int GOHALT_ON_CYC = 393218;
	localparam int BUSY_CMD_CYC = 5;
	localparam int BUSY_EXT_CYC = 7;
	localparam int BUSY_OFF_CYC = 2;
	localparam int SELECT_DELAY_CYC = 6;
	localparam int PATTERN_BYTES = 64;
	localparam int PATTERN_COUNT = 32;
	localparam int DOWNLOAD_MIN_CYC = 594;
	localparam int FILT_W = 20;
	localparam int TIMER_W = 24;

	// Clear pulse width per code (code 111 treated as 110)
	localparam logic [TIMER_W-1:0] EPW_CYC [8] = '{
		24'd125, 24'd992, 24'd3968, 24'd15872, 24'd126976, 24'd507904, 24'd1015808, 24'd1015808};
	// Clear off timer per code (code 000 means no off time)
	localparam logic [TIMER_W-1:0] ETW_CYC [8] = '{
		24'd0, 24'd125, 24'd15872, 24'd507904, 24'd1015808, 24'd2031616, 24'd4063232, 24'd8126464};

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic pulse_a;
		logic pulse_b;
		logic enc_a;
		logic enc_b;
		logic enc_z;
		logic plus_dir;
		logic minus_dir;
		logic origin;
		logic slowdown;
		logic plus_limit;
		logic minus_limit;
		logic in_pos;
		logic halt;
		logic go;
	} pct_inputs_t;

	typedef enum logic [1:0] {
		PCT_RESETTING,
		PCT_IDLE,
		PCT_SELECT,
		PCT_LOADING
	} pct_mode_t;

endpackage

/* core/pct_core.sv */
// Purpose: Input filters, clear pulse, busy timing and memory download timing
// Assumes: Inputs synchronous to clk_in; single-word AHB-Lite access
// Notes: Filter lengths counted from the first differing sample
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1 - Reset must be held at least eight clock cycles by the outside.
// R2 - Internal reset finishes eight to nine cycles after release.
// R3 - Command pulses accepted after 1 cycle, or 3 with pulse filter.
// R4 - Manual direction needs 131072 stable cycles, or 393216 with filter.
// R5 - Encoder inputs accepted after 1 cycle, or 3 with encoder filter.
// R6 - Origin accepted after 1 cycle, or 40 with sensor filter.
// R7 - Slowdown accepted after 1 cycle, or 40 with sensor filter.
// R8 - End limits accepted after 1 cycle, or 40 with sensor filter.
// R9 - In-position accepted after 1 cycle, or 40 with sensor filter.
// R10 - Halt input needs 5 cycles, or 393218 with go/halt filter.
// R11 - Go input needs 5 cycles, or 393218 with go/halt filter.
// R12 - Clear pulse width chosen by three-bit code, 125 up to 1015808 cycles.
// R13 - Off timer after clear pulse chosen by three-bit code.
// R14 - Busy asserts 5-6 cycles after command, 7-8 after go input.
// R15 - Busy deasserts at least two cycles after completion.
// R16 - Memory serial clock period at least two reference cycles.
// R17 - Memory select changes six to seven cycles after download trigger.
// R18 - Download of one pattern takes at least 594 cycles.
// R19 - Each filter: synchroniser then stability counter updating accepted level.
// R20 - Memory holds 32 patterns of 64 bytes each.
module pct_core #(
	parameter int MANUAL_OFF = pct_pkg::MANUAL_OFF_CYC,
	parameter int MANUAL_ON = pct_pkg::MANUAL_ON_CYC,
	parameter int GOHALT_ON = pct_pkg::GOHALT_ON_CYC,
	parameter int CLEAR_SCALE = 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire pct_pkg::pct_inputs_t raw_in,
	input wire logic motion_done_in,
	output pct_pkg::pct_inputs_t filtered_out,
	output logic deviation_counter_clear_output_out,
	output logic busy_output_out,
	output logic memory_select_output_out,
	output logic memory_clock_out,
	output logic [10:0] memory_byte_addr_out
);

	localparam int N = $bits(pct_pkg::pct_inputs_t);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pct_pkg::pct_mode_t mode;
		logic [3:0] rst_cnt;
		logic [N-1:0] sync1;
		logic [N-1:0] sync2;
		logic [N-1:0] acc;
		logic [N-1:0][pct_pkg::FILT_W-1:0] fcnt;
		logic [31:0] env1;
		logic [31:0] env2;
		logic [4:0] pattern;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [4:0] start_sh;
		logic [5:0] go_sh;
		logic busy;
		logic [1:0] done_sh;
		logic clr_on;
		logic clr_off;
		logic [pct_pkg::TIMER_W-1:0] clr_cnt;
		logic [2:0] sel_cnt;
		logic sel;
		logic sck;
		logic [9:0] dl_cnt;
		logic go_prev;
	} pct_state_t;

	pct_state_t s_reg;
	pct_state_t s_next;

	// ----------------------------------------
	// Filter lengths per input
	// ----------------------------------------
	logic [N-1:0][pct_pkg::FILT_W-1:0] need;
	logic [2:0] clear_pulse_width_select;
	logic [2:0] clear_off_timer_select;
	logic sensor_filter_enable;
	logic pulse_filter_enable;
	logic encoder_filter_enable;
	logic go_halt_filter_enable;
	logic [N-1:0] raw_vec;

	assign raw_vec = raw_in;
	assign sensor_filter_enable = s_reg.env1[pct_pkg::ENV1_SENSOR_FILTER_ENABLE_BIT];
	assign clear_pulse_width_select = s_reg.env1[pct_pkg::ENV1_EPW_LSB +: 3];
	assign clear_off_timer_select = s_reg.env1[pct_pkg::ENV1_ETW_LSB +: 3];
	assign pulse_filter_enable = s_reg.env2[pct_pkg::ENV2_PULSE_FILTER_ENABLE_BIT];
	assign encoder_filter_enable = s_reg.env2[pct_pkg::ENV2_ENCODER_FILTER_ENABLE_BIT];
	assign go_halt_filter_enable = s_reg.env2[pct_pkg::ENV2_GO_HALT_FILTER_ENABLE_BIT];

	// Bit order follows the struct: go is bit 0, pulse_a is bit 13
	always_comb begin
		need[13] = pulse_filter_enable ? pct_pkg::FILT_W'(pct_pkg::PULSE_FILT_CYC) : pct_pkg::FILT_W'(1); // R3
		need[12] = need[13];
		need[11] = encoder_filter_enable ? pct_pkg::FILT_W'(pct_pkg::ENC_FILT_CYC) : pct_pkg::FILT_W'(1); // R5
		need[10] = need[11];
		need[9] = need[11];
		need[8] = pulse_filter_enable ? pct_pkg::FILT_W'(MANUAL_ON) : pct_pkg::FILT_W'(MANUAL_OFF); // R4
		need[7] = need[8];
		need[6] = sensor_filter_enable ? pct_pkg::FILT_W'(pct_pkg::SENSOR_FILT_CYC) : pct_pkg::FILT_W'(1); // R6
		need[5] = need[6]; // R7
		need[4] = need[6]; // R8
		need[3] = need[6];
		need[2] = need[6]; // R9
		need[1] = go_halt_filter_enable ? pct_pkg::FILT_W'(GOHALT_ON) : pct_pkg::FILT_W'(pct_pkg::GOHALT_OFF_CYC); // R10
		need[0] = need[1]; // R11
	end

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic take;
	logic wr_now;
	logic [31:0] rd_mux;

	assign take = hsel_in && hready_in && htrans_in[1];
	assign wr_now = s_reg.ap_valid && s_reg.ap_write;

	always_comb begin
		unique case (s_reg.ap_addr)
			pct_pkg::ENV_ONE_ADDR: rd_mux = s_reg.env1;
			pct_pkg::ENV_TWO_ADDR: rd_mux = s_reg.env2;
			pct_pkg::COMMAND_ADDR: rd_mux = {27'h0000000, s_reg.pattern};
			pct_pkg::STATUS_ADDR: rd_mux = {24'h000000, s_reg.sel, s_reg.clr_off, s_reg.clr_on,
				s_reg.busy, 2'h0, s_reg.mode};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic go_edge;
	logic [pct_pkg::TIMER_W-1:0] width_cyc;
	logic [pct_pkg::TIMER_W-1:0] off_cyc;

	assign go_edge = s_reg.acc[0] && !s_reg.go_prev;
	assign width_cyc = pct_pkg::TIMER_W'(pct_pkg::EPW_CYC[clear_pulse_width_select] / pct_pkg::TIMER_W'(CLEAR_SCALE)); // R12
	assign off_cyc = pct_pkg::TIMER_W'(pct_pkg::ETW_CYC[clear_off_timer_select] / pct_pkg::TIMER_W'(CLEAR_SCALE)); // R13

	always_comb begin
		s_next = s_reg;
		s_next.sync1 = raw_vec;
		s_next.sync2 = s_reg.sync1;
		for (int i = 0; i < N; i++) begin
			if (s_reg.sync2[i] == s_reg.acc[i]) begin
				s_next.fcnt[i] = '0;
			end else if (s_reg.fcnt[i] + pct_pkg::FILT_W'(1) >= need[i]) begin
				s_next.acc[i] = s_reg.sync2[i]; // R19
				s_next.fcnt[i] = '0;
			end else begin
				s_next.fcnt[i] = s_reg.fcnt[i] + pct_pkg::FILT_W'(1);
			end
		end
		s_next.go_prev = s_reg.acc[0];
		s_next.ap_valid = take;
		if (take) begin
			s_next.ap_write = hwrite_in;
			s_next.ap_addr = haddr_in[7:0];
		end
		s_next.start_sh = {s_reg.start_sh[3:0], 1'b0};
		s_next.go_sh = {s_reg.go_sh[4:0], 1'b0};
		s_next.done_sh = {s_reg.done_sh[0], motion_done_in && s_reg.busy};
		s_next.sck = 1'b0;
		unique case (s_reg.mode)
			pct_pkg::PCT_RESETTING: begin
				s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
				if (s_reg.rst_cnt == 4'(pct_pkg::RESET_DELAY_CYC - 1)) begin
					s_next.mode = pct_pkg::PCT_IDLE; // R2
				end
			end
			pct_pkg::PCT_IDLE: begin
				if (wr_now && s_reg.ap_addr == pct_pkg::COMMAND_ADDR && hwdata_in[pct_pkg::CMD_LOAD_BIT]) begin
					s_next.mode = pct_pkg::PCT_SELECT;
					s_next.sel_cnt = 3'h0;
					s_next.pattern = hwdata_in[pct_pkg::CMD_PAT_LSB +: 5]; // R20
				end
			end
			pct_pkg::PCT_SELECT: begin
				s_next.sel_cnt = s_reg.sel_cnt + 3'h1;
				if (s_reg.sel_cnt == 3'(pct_pkg::SELECT_DELAY_CYC - 1)) begin
					s_next.sel = 1'b1; // R17
					s_next.mode = pct_pkg::PCT_LOADING;
					s_next.dl_cnt = 10'h000;
				end
			end
			pct_pkg::PCT_LOADING: begin
				s_next.sck = !s_reg.sck; // R16
				s_next.dl_cnt = s_reg.dl_cnt + 10'h001;
				if (s_reg.dl_cnt == 10'(pct_pkg::DOWNLOAD_MIN_CYC - 1)) begin
					s_next.sel = 1'b0; // R18
					s_next.sck = 1'b0;
					s_next.mode = pct_pkg::PCT_IDLE;
				end
			end
		endcase
		if (wr_now && s_reg.mode != pct_pkg::PCT_RESETTING) begin
			if (s_reg.ap_addr == pct_pkg::ENV_ONE_ADDR) begin
				s_next.env1 = hwdata_in;
			end
			if (s_reg.ap_addr == pct_pkg::ENV_TWO_ADDR) begin
				s_next.env2 = hwdata_in;
			end
			if (s_reg.ap_addr == pct_pkg::COMMAND_ADDR && hwdata_in[pct_pkg::CMD_START_BIT] && !s_reg.busy) begin
				s_next.start_sh[0] = 1'b1;
			end
			if (s_reg.ap_addr == pct_pkg::COMMAND_ADDR && hwdata_in[pct_pkg::CMD_STOP_BIT]) begin
				s_next.done_sh[0] = s_reg.busy;
			end
			if (s_reg.ap_addr == pct_pkg::COMMAND_ADDR && hwdata_in[pct_pkg::CMD_CLEAR_BIT]
				&& !s_reg.clr_on && !s_reg.clr_off) begin
				s_next.clr_on = 1'b1;
				s_next.clr_cnt = width_cyc;
			end
		end
		if (go_edge && !s_reg.busy && s_reg.mode == pct_pkg::PCT_IDLE) begin
			s_next.go_sh[0] = 1'b1;
		end
		if (s_reg.acc[1] && s_reg.busy) begin
			s_next.done_sh[0] = 1'b1;
		end
		// Busy 5 cycles after command data, 7 after filtered go
		if (s_reg.start_sh[4] || s_reg.go_sh[5]) begin
			s_next.busy = 1'b1; // R14
		end else if (s_reg.done_sh[1]) begin
			s_next.busy = 1'b0; // R15
		end
		// Clear pulse then off time
		if (s_reg.clr_on || s_reg.clr_off) begin
			if (s_reg.clr_cnt <= pct_pkg::TIMER_W'(1)) begin
				s_next.clr_on = 1'b0;
				s_next.clr_off = s_reg.clr_on && off_cyc != '0; // R13
				s_next.clr_cnt = off_cyc;
			end else begin
				s_next.clr_cnt = s_reg.clr_cnt - pct_pkg::TIMER_W'(1); // R12
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			s_reg <= '0;
			s_reg.mode <= pct_pkg::PCT_RESETTING; // R1
			s_reg.env1 <= pct_pkg::ENV1_RESET;
			s_reg.env2 <= pct_pkg::ENV2_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign hrdata_out = rd_mux;
	assign filtered_out = s_reg.acc;
	assign deviation_counter_clear_output_out = s_reg.clr_on;
	assign busy_output_out = s_reg.busy;
	assign memory_select_output_out = s_reg.sel;
	assign memory_clock_out = s_reg.sck;
	assign memory_byte_addr_out = {s_reg.pattern, 6'h00}; // R20

endmodule

`default_nettype wire

/* dv/pct_core_props.sv */
// Purpose: Concurrent checks on the timing core ports
// Assumes: Bench runs CLEAR_SCALE 1 and clear width code 000
// Notes: Bound into pct_core at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module pct_core_props (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic motion_done_in,
	input wire pct_pkg::pct_inputs_t filtered_out,
	input wire logic deviation_counter_clear_output_out,
	input wire logic busy_output_out,
	input wire logic memory_select_output_out,
	input wire logic memory_clock_out,
	input wire logic [10:0] memory_byte_addr_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic cmd_q, go_q;
	int sel_cnt, clr_cnt;
	wire logic busy = busy_output_out;
	wire logic sel = memory_select_output_out;
	wire logic clr = deviation_counter_clear_output_out;
	wire logic start_d = cmd_q && hwdata_in[pct_pkg::CMD_START_BIT];
	wire logic load_d = cmd_q && hwdata_in[pct_pkg::CMD_LOAD_BIT];
	wire logic go_edge = filtered_out.go && !go_q;
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			cmd_q <= 1'b0;
			go_q <= 1'b0;
			sel_cnt <= 0;
			clr_cnt <= 0;
		end else begin
			cmd_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == pct_pkg::COMMAND_ADDR;
			go_q <= filtered_out.go;
			sel_cnt <= sel ? sel_cnt + 1 : 0;
			clr_cnt <= clr ? clr_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_reset_quiet; $rose(resetn_in) |-> !busy [*8]; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("busy during reset processing");
	property p_busy_on;
		$rose(busy) |-> $past(start_d, 6) || $past(start_d, 7) || $past(go_edge, 7) || $past(go_edge, 8) || $past(go_edge, 9);
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy rose off its start delay");
	property p_busy_off; $rose(motion_done_in) && busy |=> busy ##[1:3] !busy; endproperty
	a_busy_off: assert property (p_busy_off) else $error("busy end delay wrong");
	property p_load_sel; $rose(sel) |-> $past(load_d, 7) || $past(load_d, 8); endproperty
	a_load_sel: assert property (p_load_sel) else $error("select rose off its delay");
	property p_sck_frame; $changed(memory_clock_out) |-> sel || $past(sel); endproperty
	a_sck_frame: assert property (p_sck_frame) else $error("memory clock outside frame");
	property p_sel_len; $fell(sel) |-> sel_cnt >= pct_pkg::DOWNLOAD_MIN_CYC; endproperty
	a_sel_len: assert property (p_sel_len) else $error("download too short");
	property p_clr_len; $fell(clr) |-> clr_cnt >= 125; endproperty
	a_clr_len: assert property (p_clr_len) else $error("clear pulse too short");
	property p_addr; sel |-> memory_byte_addr_out[5:0] == 6'h00 && $stable(memory_byte_addr_out); endproperty
	a_addr: assert property (p_addr) else $error("pattern address not aligned or moving");
endmodule
bind pct_core pct_core_props pct_core_props_i (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
	.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
	.hready_in(hready_in), .motion_done_in(motion_done_in), .filtered_out(filtered_out),
	.deviation_counter_clear_output_out(deviation_counter_clear_output_out), .busy_output_out(busy_output_out),
	.memory_select_output_out(memory_select_output_out), .memory_clock_out(memory_clock_out),
	.memory_byte_addr_out(memory_byte_addr_out));
`default_nettype wire

/* dv/pct_far_side.sv */
// Purpose: Motor driver and serial memory stand-in
// Assumes: Completion after a bench-chosen busy time
// Notes: Counts memory clock rises inside frames
`timescale 1ns/100ps
`default_nettype none
module pct_far_side (
	input wire logic clk_in,
	input wire logic busy_in,
	input wire logic select_in,
	input wire logic sck_in,
	input wire logic [15:0] hold_in,
	output var logic done_out,
	output var int rises_out
);
	int run = 0;
	logic sck_q = 1'b0;
	initial begin
		done_out = 1'b0;
		rises_out = 0;
	end
	always @(posedge clk_in) begin
		run <= busy_in ? run + 1 : 0;
		done_out <= busy_in && run == int'(hold_in);
		sck_q <= sck_in;
		if (select_in && sck_in && !sck_q) rises_out <= rises_out + 1;
	end
endmodule
`default_nettype wire

/* dv/pct_core_tb.sv */
// Purpose: Self-checking bench for the timing core
// Assumes: Shortened manual and go/halt filters
// Notes: Filter needs come from need()
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
	$display("unexpected %s exp %0h got %0h", nm, e, s); end end
module pct_core_tb;
	localparam int M_OFF = 20, M_ON = 60, G_ON = 50;
	logic clk_in = 1'b0, resetn_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, done;
	logic clear, busy, sel, sck;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rq;
	logic [10:0] baddr;
	logic [15:0] hold = 16'h000A;
	pct_pkg::pct_inputs_t drv = '0, filt;
	int rises, err_count = 0, samples_checked = 0, seed = 32'hA7F77E93;
	always #2 clk_in = ~clk_in;
	pct_core #(.MANUAL_OFF(M_OFF), .MANUAL_ON(M_ON), .GOHALT_ON(G_ON), .CLEAR_SCALE(1)) pct_core_i (
		.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .raw_in(drv), .motion_done_in(done), .filtered_out(filt),
		.deviation_counter_clear_output_out(clear), .busy_output_out(busy), .memory_select_output_out(sel),
		.memory_clock_out(sck), .memory_byte_addr_out(baddr));
	pct_far_side pct_far_side_i (.clk_in(clk_in), .busy_in(busy), .select_in(sel), .sck_in(sck),
		.hold_in(hold), .done_out(done), .rises_out(rises));
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic edge_rdy();
		int n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		q = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic count_to(input int w, input logic v, input int lim, output int n);
		n = 0;
		#1;
		while ((w == 0 ? busy : (w == 1 ? sel : clear)) !== v && n < lim) begin
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask
	function automatic int need(input int b, input int fe);
		if (b >= 9) return fe ? 3 : 1;
		if (b >= 7) return fe ? M_ON : M_OFF;
		if (b >= 2) return fe ? 40 : 1;
		return fe ? G_ON : 5;
	endfunction
	task automatic pulse(input int b, input int len, input logic exp);
		int n;
		logic seen = 1'b0;
		@(posedge clk_in);
		drv[b] <= 1'b1;
		for (n = 0; n < len + 120; n++) begin
			@(posedge clk_in);
			if (n == len - 1) drv[b] <= 1'b0;
			seen |= filt[b];
		end
		`CHK("filter", exp, seen)
	endtask
	initial begin
		#400000;
		err_count++;
		summarize();
	end
	initial begin
		int n, p, fe, b;
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		bus(0, pct_pkg::STATUS_ADDR, 0, rq);
		`CHK("mode", pct_pkg::PCT_RESETTING, rq[1:0])
		bus(1, pct_pkg::ENV_ONE_ADDR, 32'h1, rq);
		repeat (6) @(posedge clk_in);
		bus(0, pct_pkg::STATUS_ADDR, 0, rq);
		`CHK("mode", pct_pkg::PCT_IDLE, rq[1:0])
		bus(0, pct_pkg::ENV_ONE_ADDR, 0, rq);
		`CHK("env1", pct_pkg::ENV1_RESET, rq)
		bus(0, pct_pkg::ENV_TWO_ADDR, 0, rq);
		`CHK("env2", pct_pkg::ENV2_RESET, rq)
		bus(0, 8'h10 | (8'($random(seed)) & 8'hEC), 0, rq);
		`CHK("unmapped", 32'h0, rq)
		$display("test reset done");
		for (fe = 0; fe < 2; fe++) begin
			bus(1, pct_pkg::ENV_ONE_ADDR, 32'(fe), rq);
			bus(1, pct_pkg::ENV_TWO_ADDR, 32'(fe * 7), rq);
			for (b = 0; b < 14; b++) begin
				pulse(b, need(b, fe), 1'b1);
				if (need(b, fe) > 1) pulse(b, need(b, fe) - 1, 1'b0);
			end
		end
		$display("test filters done");
		hold <= 16'h0400;
		bus(1, pct_pkg::COMMAND_ADDR, 32'h1, rq);
		count_to(0, 1'b1, 20, n);
		`CHK("busy_on", 1'b1, n >= 5 && n <= 6)
		bus(1, pct_pkg::COMMAND_ADDR, 32'h2, rq);
		count_to(0, 1'b0, 20, n);
		`CHK("busy_off", 1'b1, n >= 2 && n <= 4)
		$display("test busy done");
		bus(1, pct_pkg::ENV_ONE_ADDR, 32'h0000_0100, rq);
		bus(1, pct_pkg::COMMAND_ADDR, 32'h4, rq);
		count_to(2, 1'b1, 20, n);
		count_to(2, 1'b0, 200, n);
		`CHK("clear_width", 1'b1, n >= 125 && n <= 126)
		bus(1, pct_pkg::COMMAND_ADDR, 32'h4, rq);
		count_to(2, 1'b1, 110, n);
		`CHK("clear_off", 110, n)
		repeat (20) @(posedge clk_in);
		bus(1, pct_pkg::COMMAND_ADDR, 32'h4, rq);
		count_to(2, 1'b1, 20, n);
		`CHK("clear_again", 1'b1, n < 20)
		$display("test clear done");
		p = $random(seed) & 31;
		bus(1, pct_pkg::COMMAND_ADDR, 32'(p) << 8 | 32'h8, rq);
		count_to(1, 1'b1, 20, n);
		`CHK("select_delay", 1'b1, n >= 6 && n <= 7)
		`CHK("pattern_addr", 11'(p * 64), baddr)
		count_to(1, 1'b0, 2000, n);
		`CHK("load_len", 1'b1, n >= 594 && n < 2000)
		`CHK("sck_rate", 1'b1, rises > 0 && rises * 2 <= n)
		$display("test load done");
		summarize();
	end
endmodule
`default_nettype wire
